// ===== amc_regs.sv
// What this block does
// - Timing and output latency do not depend on double sampling select.
// - Host writes 8-bit codes to six-bit addresses over the serial port.
// - Registers reset to 0F, 23, 1F, 05, 00, offsets 80, gains 00.
// - Setup one bit 0 is power enable; clear powers down, resets to one.
// - Setup one bit 1 selects double sampling versus clamp-referenced sampling; resets one.
// - Setup one bits 5:4 pick mid, full positive or full negative zero code.
// - Setup one bit 6 marks maximum speed mode only; resets to zero.
// - Setup two bit 2 inverts output code polarity; resets to zero.
// - Setup two bit 3 powers down clamp DAC, output high impedance.
// - Six address bits then eight data bits, MSB first, strobe commits.
// - Any write to the soft reset address restores all register defaults.
// - Address bit 4 set requests read-back, shifted out MSB first on falling edges.
// - Setup two bits 7:6 delay output by zero to three ADC clocks.
`timescale 1ns/1ps
`default_nettype none

module amc_regs
    import amc_pkg::*;
#(
    parameter logic [7:0] REVISION_VALUE = 8'h5A  // Arbitrary identification value
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Serial control pins
    input  wire logic        sclk,
    input  wire logic        serial_in,
    input  wire logic        serial_strobe,
    output logic             serial_out,
    output logic             readback_active,
    // Operating mode strap
    input  wire logic        fast_mode,
    // Configuration
    output amc_cfg_type      cfg,
    output logic             power_down,
    output logic             clamp_dac_hiz,
    output logic [3:0]       latency_mclk,
    output logic [15:0]      zero_input_code,
    output logic             config_conflict
);

    logic [3:0]            pin_level;
    logic [3:0]            pin_rise;
    logic [3:0]            pin_fall;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  strobe_rise;
    logic                  data_bit;
    logic                  fast_level;
    logic                  commit_write;
    logic                  commit_read;
    logic                  load_defaults;

    // Frame
    logic [FRAME_W-1:0]    frame_reg;
    logic [7:0]            regs_reg [NUM_SLOTS];

    // Decode
    logic [ADDR_W-1:0]     frame_addr;
    logic [DATA_W-1:0]     frame_data;
    logic [ADDR_W-1:0]     target_addr;
    logic [4:0]            target_slot;
    logic                  is_read;
    logic                  is_soft_reset;
    logic [7:0]            read_value;

    // Read-back
    amc_rb_state_type      rb_state_reg;
    amc_rb_state_type      rb_state_next;
    logic [7:0]            rb_shift_reg;
    logic [BIT_CNT_W-1:0]  rb_count_reg;
    logic                  serial_out_reg;
    logic                  conflict_cds_max;
    logic                  conflict_mode_bit;
    logic                  conflict_fast_timing;

    // Pin synchronisers
    amc_pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .mclk      (mclk),
        .srst      (srst),
        .pin_async ({fast_mode, serial_strobe, serial_in, sclk}),
        .pin_level (pin_level),
        .pin_rise  (pin_rise),
        .pin_fall  (pin_fall)
    );

    assign sclk_rise   = pin_rise[0];
    assign sclk_fall   = pin_fall[0];
    assign data_bit    = pin_level[1];
    assign strobe_rise = pin_rise[2];
    assign fast_level  = pin_level[3];

    // Frame shift on rising serial clock
    always_ff @(posedge mclk) begin
        if (srst) begin
            frame_reg <= '0;
        end else if (sclk_rise) begin
            frame_reg <= {frame_reg[FRAME_W-2:0], data_bit};
        end
    end

    // Frame decode
    assign frame_addr    = frame_reg[FRAME_W-1:DATA_W];
    assign frame_data    = frame_reg[DATA_W-1:0];
    assign is_read       = frame_addr[READ_FLAG_BIT];
    assign target_addr   = frame_addr & ~(6'h01 << READ_FLAG_BIT);
    assign target_slot   = slot_lookup(target_addr);
    assign is_soft_reset = !is_read && (frame_addr == ADDR_SOFT_RESET);

    // Commit strobes
    assign commit_write  = strobe_rise && !is_read;
    assign commit_read   = strobe_rise && is_read;
    assign load_defaults = srst || (strobe_rise && is_soft_reset);

    // Register storage
    always_ff @(posedge mclk) begin
        if (load_defaults) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                regs_reg[i] <= RESET_VALUES[i];
            end
        end else if (commit_write) begin
            if (target_addr == ADDR_OFFSET_ALL) begin
                regs_reg[SLOT_OFFSET_RED]   <= frame_data;
                regs_reg[SLOT_OFFSET_GREEN] <= frame_data;
                regs_reg[SLOT_OFFSET_BLUE]  <= frame_data;
            end else if (target_addr == ADDR_GAIN_ALL) begin
                regs_reg[SLOT_GAIN_RED]   <= frame_data;
                regs_reg[SLOT_GAIN_GREEN] <= frame_data;
                regs_reg[SLOT_GAIN_BLUE]  <= frame_data;
            end else if (target_slot[4]) begin
                regs_reg[target_slot[3:0]] <= frame_data;
            end
        end
    end

    // Read-back source
    always_comb begin
        if (target_addr == ADDR_REVISION_ID) begin
            read_value = REVISION_VALUE;
        end else if (target_slot[4]) begin
            read_value = regs_reg[target_slot[3:0]];
        end else begin
            read_value = 8'h00;
        end
    end

    // Read-back state
    always_comb begin
        rb_state_next = rb_state_reg;
        case (rb_state_reg)
            RB_IDLE: begin
                if (commit_read) begin
                    rb_state_next = RB_SHIFT;
                end
            end
            RB_SHIFT: begin
                if (sclk_fall && rb_count_reg == 4'h0) begin
                    rb_state_next = RB_IDLE;
                end
            end
            default: begin
                rb_state_next = RB_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rb_state_reg <= RB_IDLE;
        end else begin
            rb_state_reg <= rb_state_next;
        end
    end

    // Read-back shifter, MSB first on falling serial clock
    always_ff @(posedge mclk) begin
        if (srst) begin
            rb_shift_reg   <= 8'h00;
            rb_count_reg   <= 4'h0;
            serial_out_reg <= 1'b0;
        end else if (commit_read) begin
            rb_shift_reg   <= read_value;
            rb_count_reg   <= 4'h8;
            serial_out_reg <= 1'b0;
        end else if (rb_state_reg == RB_SHIFT && sclk_fall) begin
            if (rb_count_reg != 4'h0) begin
                serial_out_reg <= rb_shift_reg[7];
                rb_shift_reg   <= {rb_shift_reg[6:0], 1'b0};
                rb_count_reg   <= rb_count_reg - 4'h1;
            end else begin
                serial_out_reg <= 1'b0;
            end
        end
    end

    assign serial_out      = serial_out_reg;
    assign readback_active = (rb_state_reg == RB_SHIFT);

    // Field map
    always_comb begin
        cfg.power_enable           = regs_reg[SLOT_SETUP_ONE][POWER_BIT];
        cfg.double_sampling_select = regs_reg[SLOT_SETUP_ONE][DSS_BIT];
        cfg.adc_range_offset       = amc_range_type'(regs_reg[SLOT_SETUP_ONE][RANGE_LSB +: 2]);
        cfg.max_speed_select       = regs_reg[SLOT_SETUP_ONE][MAX_SPEED_BIT];
        cfg.output_invert          = regs_reg[SLOT_SETUP_TWO][INVERT_BIT];
        cfg.external_clamp_ref     = regs_reg[SLOT_SETUP_TWO][EXT_REF_BIT];
        cfg.clamp_dac_range        = regs_reg[SLOT_SETUP_TWO][DAC_RANGE_BIT];
        cfg.output_latency         = regs_reg[SLOT_SETUP_TWO][LATENCY_LSB +: 2];
        cfg.clamp_dac_code         = regs_reg[SLOT_SETUP_THREE][CLAMP_CODE_LSB +: 4];
        cfg.reset_sample_timing    = regs_reg[SLOT_SETUP_THREE][RST_TIMING_LSB +: 2];
        cfg.clamp_enable           = regs_reg[SLOT_SETUP_FOUR][CLAMP_EN_BIT];
        cfg.colour_select          = regs_reg[SLOT_SETUP_FOUR][COLOUR_LSB +: 2];
        cfg.sync_detect_enable     = regs_reg[SLOT_SETUP_FIVE][DETECT_BIT];
        cfg.sync_pulse_delay       = regs_reg[SLOT_SETUP_FIVE][SYNC_DELAY_LSB +: 3];
        cfg.sync_edge_polarity     = regs_reg[SLOT_SETUP_FIVE][SYNC_POL_BIT];
        cfg.test_clock_bit         = regs_reg[SLOT_TEST_ONE][TEST_CLOCK_BIT];
        cfg.offset_code_red        = regs_reg[SLOT_OFFSET_RED];
        cfg.offset_code_green      = regs_reg[SLOT_OFFSET_GREEN];
        cfg.offset_code_blue       = regs_reg[SLOT_OFFSET_BLUE];
        cfg.gain_code_red          = regs_reg[SLOT_GAIN_RED];
        cfg.gain_code_green        = regs_reg[SLOT_GAIN_GREEN];
        cfg.gain_code_blue         = regs_reg[SLOT_GAIN_BLUE];
    end

    // Derived controls
    logic [15:0] range_code;
    logic [1:0]  adc_periods;
    logic [3:0]  latency_next;

    always_comb begin
        case (cfg.adc_range_offset)
            RANGE_POS: range_code = ZERO_CODE_POS;
            RANGE_NEG: range_code = ZERO_CODE_NEG;
            default:   range_code = ZERO_CODE_MID;
        endcase
    end

    // ADC period length depends on mode only, never on sampling scheme
    assign adc_periods  = fast_level ? ADC_PERIODS_FAST : ADC_PERIODS_NORMAL;
    assign latency_next = 4'(cfg.output_latency * adc_periods);

    // Settings that the selected mode forbids
    assign conflict_cds_max     = cfg.max_speed_select && cfg.double_sampling_select;
    assign conflict_mode_bit    = cfg.max_speed_select && fast_level;
    assign conflict_fast_timing = fast_level && cfg.double_sampling_select
                                  && cfg.reset_sample_timing != 2'b00;

    // Power state
    always_ff @(posedge mclk) begin
        if (srst) begin
            power_down <= 1'b0;
        end else begin
            power_down <= ~cfg.power_enable;
        end
    end

    // Clamp reference
    always_ff @(posedge mclk) begin
        if (srst) begin
            clamp_dac_hiz <= 1'b0;
        end else begin
            clamp_dac_hiz <= cfg.external_clamp_ref;
        end
    end

    // Output latency
    always_ff @(posedge mclk) begin
        if (srst) begin
            latency_mclk <= 4'h0;
        end else begin
            latency_mclk <= latency_next;
        end
    end

    // Zero-input code
    always_ff @(posedge mclk) begin
        if (srst) begin
            zero_input_code <= ZERO_CODE_MID;
        end else begin
            zero_input_code <= cfg.output_invert ? ~range_code : range_code;
        end
    end

    // Mode conflict
    always_ff @(posedge mclk) begin
        if (srst) begin
            config_conflict <= 1'b0;
        end else begin
            config_conflict <= conflict_cds_max || conflict_mode_bit || conflict_fast_timing;
        end
    end

endmodule : amc_regs

`default_nettype wire

// ===== amc_pkg.sv
package amc_pkg;

    // Serial frame geometry
    localparam int ADDR_W        = 6;
    localparam int DATA_W        = 8;
    localparam int FRAME_W       = 14;
    localparam int READ_FLAG_BIT = 4;
    localparam int NUM_SLOTS     = 15;
    localparam int SLOT_W        = 4;
    localparam int BIT_CNT_W     = 4;

    // Register addresses
    localparam logic [5:0] ADDR_SETUP_ONE     = 6'h01;
    localparam logic [5:0] ADDR_SETUP_TWO     = 6'h02;
    localparam logic [5:0] ADDR_SETUP_THREE   = 6'h03;
    localparam logic [5:0] ADDR_SOFT_RESET    = 6'h04;
    localparam logic [5:0] ADDR_SETUP_FOUR    = 6'h06;
    localparam logic [5:0] ADDR_REVISION_ID   = 6'h07;
    localparam logic [5:0] ADDR_SETUP_FIVE    = 6'h08;
    localparam logic [5:0] ADDR_TEST_ONE      = 6'h09;
    localparam logic [5:0] ADDR_SPARE_A       = 6'h0A;
    localparam logic [5:0] ADDR_SPARE_B       = 6'h0B;
    localparam logic [5:0] ADDR_SPARE_C       = 6'h0C;
    localparam logic [5:0] ADDR_OFFSET_RED    = 6'h20;
    localparam logic [5:0] ADDR_OFFSET_GREEN  = 6'h21;
    localparam logic [5:0] ADDR_OFFSET_BLUE   = 6'h22;
    localparam logic [5:0] ADDR_OFFSET_ALL    = 6'h23;
    localparam logic [5:0] ADDR_GAIN_RED      = 6'h28;
    localparam logic [5:0] ADDR_GAIN_GREEN    = 6'h29;
    localparam logic [5:0] ADDR_GAIN_BLUE     = 6'h2A;
    localparam logic [5:0] ADDR_GAIN_ALL      = 6'h2B;

    // Storage slots
    localparam logic [3:0] SLOT_SETUP_ONE    = 4'h0;
    localparam logic [3:0] SLOT_SETUP_TWO    = 4'h1;
    localparam logic [3:0] SLOT_SETUP_THREE  = 4'h2;
    localparam logic [3:0] SLOT_SETUP_FOUR   = 4'h3;
    localparam logic [3:0] SLOT_SETUP_FIVE   = 4'h4;
    localparam logic [3:0] SLOT_TEST_ONE     = 4'h5;
    localparam logic [3:0] SLOT_SPARE_A      = 4'h6;
    localparam logic [3:0] SLOT_SPARE_B      = 4'h7;
    localparam logic [3:0] SLOT_SPARE_C      = 4'h8;
    localparam logic [3:0] SLOT_OFFSET_RED   = 4'h9;
    localparam logic [3:0] SLOT_OFFSET_GREEN = 4'hA;
    localparam logic [3:0] SLOT_OFFSET_BLUE  = 4'hB;
    localparam logic [3:0] SLOT_GAIN_RED     = 4'hC;
    localparam logic [3:0] SLOT_GAIN_GREEN   = 4'hD;
    localparam logic [3:0] SLOT_GAIN_BLUE    = 4'hE;

    // Reset values, by slot
    localparam logic [7:0] RESET_VALUES [NUM_SLOTS] = '{
        8'h0F, 8'h23, 8'h1F, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};

    // Field positions
    localparam int POWER_BIT       = 0;
    localparam int DSS_BIT         = 1;
    localparam int RANGE_LSB       = 4;
    localparam int MAX_SPEED_BIT   = 6;
    localparam int INVERT_BIT      = 2;
    localparam int EXT_REF_BIT     = 3;
    localparam int DAC_RANGE_BIT   = 5;
    localparam int LATENCY_LSB     = 6;
    localparam int CLAMP_CODE_LSB  = 0;
    localparam int RST_TIMING_LSB  = 4;
    localparam int CLAMP_EN_BIT    = 3;
    localparam int COLOUR_LSB      = 4;
    localparam int DETECT_BIT      = 0;
    localparam int SYNC_DELAY_LSB  = 1;
    localparam int SYNC_POL_BIT    = 4;
    localparam int TEST_CLOCK_BIT  = 7;

    // Master-clock periods per ADC clock
    localparam logic [1:0] ADC_PERIODS_NORMAL = 2'h2;
    localparam logic [1:0] ADC_PERIODS_FAST   = 2'h3;

    // ADC code for zero PGA input
    localparam logic [15:0] ZERO_CODE_MID = 16'h7FFF;
    localparam logic [15:0] ZERO_CODE_POS = 16'hFFFF;
    localparam logic [15:0] ZERO_CODE_NEG = 16'h0000;

    typedef enum logic [1:0] {
        RANGE_MID_A = 2'b00,
        RANGE_MID_B = 2'b01,
        RANGE_POS   = 2'b10,
        RANGE_NEG   = 2'b11
    } amc_range_type;

    typedef enum logic {
        RB_IDLE  = 1'b0,
        RB_SHIFT = 1'b1
    } amc_rb_state_type;

    typedef struct packed {
        logic                power_enable;
        logic                double_sampling_select;
        amc_range_type       adc_range_offset;
        logic                max_speed_select;
        logic                output_invert;
        logic                external_clamp_ref;
        logic                clamp_dac_range;
        logic [1:0]          output_latency;
        logic [3:0]          clamp_dac_code;
        logic [1:0]          reset_sample_timing;
        logic                clamp_enable;
        logic [1:0]          colour_select;
        logic                sync_detect_enable;
        logic [2:0]          sync_pulse_delay;
        logic                sync_edge_polarity;
        logic                test_clock_bit;
        logic [7:0]          offset_code_red;
        logic [7:0]          offset_code_green;
        logic [7:0]          offset_code_blue;
        logic [7:0]          gain_code_red;
        logic [7:0]          gain_code_green;
        logic [7:0]          gain_code_blue;
    } amc_cfg_type;

    // Address to storage slot; valid low for unmapped
    function automatic logic [4:0] slot_lookup(input logic [5:0] addr);
        logic [4:0] res;
        res = 5'h00;
        if (addr == ADDR_SETUP_ONE) res = {1'b1, SLOT_SETUP_ONE};
        else if (addr == ADDR_SETUP_TWO) res = {1'b1, SLOT_SETUP_TWO};
        else if (addr == ADDR_SETUP_THREE) res = {1'b1, SLOT_SETUP_THREE};
        else if (addr == ADDR_SETUP_FOUR) res = {1'b1, SLOT_SETUP_FOUR};
        else if (addr == ADDR_SETUP_FIVE) res = {1'b1, SLOT_SETUP_FIVE};
        else if (addr == ADDR_TEST_ONE) res = {1'b1, SLOT_TEST_ONE};
        else if (addr == ADDR_SPARE_A) res = {1'b1, SLOT_SPARE_A};
        else if (addr == ADDR_SPARE_B) res = {1'b1, SLOT_SPARE_B};
        else if (addr == ADDR_SPARE_C) res = {1'b1, SLOT_SPARE_C};
        else if (addr == ADDR_OFFSET_RED) res = {1'b1, SLOT_OFFSET_RED};
        else if (addr == ADDR_OFFSET_GREEN) res = {1'b1, SLOT_OFFSET_GREEN};
        else if (addr == ADDR_OFFSET_BLUE) res = {1'b1, SLOT_OFFSET_BLUE};
        else if (addr == ADDR_GAIN_RED) res = {1'b1, SLOT_GAIN_RED};
        else if (addr == ADDR_GAIN_GREEN) res = {1'b1, SLOT_GAIN_GREEN};
        else if (addr == ADDR_GAIN_BLUE) res = {1'b1, SLOT_GAIN_BLUE};
        return res;
    endfunction : slot_lookup

endpackage : amc_pkg

// ===== amc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module amc_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Asynchronous pins
    input  wire logic [WIDTH-1:0] pin_async,
    // Synchronised level and edges
    output logic      [WIDTH-1:0] pin_level,
    output logic      [WIDTH-1:0] pin_rise,
    output logic      [WIDTH-1:0] pin_fall
);

    logic [WIDTH-1:0] stage_one_reg;
    logic [WIDTH-1:0] stage_two_reg;
    logic [WIDTH-1:0] stage_three_reg;

    // Two-flop synchroniser plus edge history; unreset so idle-high pins give no edge at release
    always_ff @(posedge mclk) begin
        stage_one_reg   <= pin_async;
        stage_two_reg   <= stage_one_reg;
        stage_three_reg <= stage_two_reg;
    end

    assign pin_level = stage_two_reg;
    assign pin_rise  = {WIDTH{~srst}} & stage_two_reg & ~stage_three_reg;
    assign pin_fall  = {WIDTH{~srst}} & ~stage_two_reg & stage_three_reg;

endmodule : amc_pin_sync

`default_nettype wire

// ===== amc_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module amc_regs_chk
    import amc_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // Serial pins
    input wire logic        sclk,
    input wire logic        serial_in,
    input wire logic        serial_strobe,
    input wire logic        serial_out,
    input wire logic        readback_active,
    input wire logic        fast_mode,
    // Configuration
    input wire amc_cfg_type cfg,
    input wire logic        power_down,
    input wire logic        clamp_dac_hiz,
    input wire logic [3:0]  latency_mclk,
    input wire logic [15:0] zero_input_code,
    input wire logic        config_conflict
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    function automatic logic [15:0] base_code(input logic [1:0] r);
        return (r == 2'h2) ? 16'hFFFF : ((r == 2'h3) ? 16'h0000 : 16'h7FFF);
    endfunction : base_code

    property p_reset_values;
        $fell(srst) |-> cfg.power_enable && cfg.double_sampling_select && !cfg.max_speed_select
            && cfg.clamp_dac_code == 4'hF && cfg.reset_sample_timing == 2'h1 && cfg.offset_code_red == 8'h80;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("Defaults missing after reset");
    property p_power;
        !$past(srst) |-> power_down == !$past(cfg.power_enable);
    endproperty
    a_power: assert property (p_power) else $error("Power down not following enable bit");
    property p_zero_code;
        !$past(srst) && !$past(cfg.output_invert) |-> zero_input_code == base_code($past(cfg.adc_range_offset));
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("Zero input code wrong");
    property p_invert;
        !$past(srst) && $past(cfg.output_invert) |-> zero_input_code == ~base_code($past(cfg.adc_range_offset));
    endproperty
    a_invert: assert property (p_invert) else $error("Inverted zero code wrong");
    property p_clamp_hiz;
        !$past(srst) |-> clamp_dac_hiz == $past(cfg.external_clamp_ref);
    endproperty
    a_clamp_hiz: assert property (p_clamp_hiz) else $error("Clamp DAC release wrong");
    property p_conflict;
        !$past(srst) && $past(cfg.max_speed_select && cfg.double_sampling_select) |-> config_conflict;
    endproperty
    a_conflict: assert property (p_conflict) else $error("Max speed with double sampling not flagged");
    property p_latency;
        $stable(cfg.output_latency) && $stable(fast_mode) && fast_mode == $past(fast_mode, 5) && !$past(srst)
            |-> latency_mclk == (fast_mode ? 4'h3 : 4'h2) * {2'h0, cfg.output_latency};
    endproperty
    a_latency: assert property (p_latency) else $error("Output latency wrong");
    property p_commit;
        $changed(cfg) && !$past(srst) |-> $past(serial_strobe);
    endproperty
    a_commit: assert property (p_commit) else $error("Register changed without strobe");
    property p_readback;
        $rose(readback_active) |-> !serial_out ##0 readback_active[*8] ##[1:300] !readback_active;
    endproperty
    a_readback: assert property (p_readback) else $error("Read-back shift wrong");
    property p_out_idle;
        !readback_active && !$past(readback_active) |-> !serial_out;
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("Serial out active while idle");
endmodule : amc_regs_chk

bind amc_regs amc_regs_chk u_chk (.mclk(mclk), .srst(srst), .sclk(sclk), .serial_in(serial_in),
    .serial_strobe(serial_strobe), .serial_out(serial_out), .readback_active(readback_active),
    .fast_mode(fast_mode), .cfg(cfg), .power_down(power_down), .clamp_dac_hiz(clamp_dac_hiz),
    .latency_mclk(latency_mclk), .zero_input_code(zero_input_code), .config_conflict(config_conflict));

`default_nettype wire

// ===== amc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module amc_host_model (
    // Clock
    input  wire logic mclk,
    // Serial pins
    output logic      sclk,
    output logic      serial_in,
    output logic      serial_strobe,
    input  wire logic serial_out
);
    initial begin
        sclk = 1'b1;
        serial_in = 1'b0;
        serial_strobe = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_n

    // Shift a frame, commit it, then clock out read-back
    task automatic xfer(input logic [13:0] frame, input logic rd, input int slow, output logic [7:0] data);
        for (int i = 13; i >= 0; i--) begin
            sclk = 1'b0;
            serial_in = frame[i];
            wait_n(5 + slow);
            sclk = 1'b1;
            wait_n(5 + slow);
        end
        serial_in = ~frame[0];
        serial_strobe = 1'b1;
        wait_n(6);
        serial_strobe = 1'b0;
        wait_n(8);
        data = 8'h00;
        for (int i = 0; i < 9 && rd; i++) begin
            sclk = 1'b0;
            serial_in = ~serial_in;
            wait_n(5);
            if (i < 8) data = {data[6:0], serial_out};
            sclk = 1'b1;
            wait_n(5);
        end
    endtask : xfer
endmodule : amc_host_model

`default_nettype wire

// ===== amc_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module amc_regs_test;
    import amc_pkg::*;
    localparam logic [7:0] REV = 8'h5A;  // Arbitrary identification value
    logic        mclk, srst, sclk, serial_in, serial_strobe, fast_mode;
    logic        serial_out, readback_active, power_down, clamp_dac_hiz, config_conflict;
    amc_cfg_type cfg;
    logic [3:0]  latency_mclk;
    logic [15:0] zero_input_code;
    logic [7:0]  rdata;
    int          fails, samples_checked, cycles;
    logic [5:0]  addr_list [16] = '{6'h01, 6'h02, 6'h03, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A,
                                   6'h0B, 6'h0C, 6'h20, 6'h21, 6'h22, 6'h28, 6'h29, 6'h2A};
    logic [7:0]  dflt_list [16] = '{8'h0F, 8'h23, 8'h1F, 8'h05, REV, 8'h00, 8'h00, 8'h00,
                                   8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};

    amc_regs #(.REVISION_VALUE(REV)) DUT (.mclk(mclk), .srst(srst), .sclk(sclk), .serial_in(serial_in),
        .serial_strobe(serial_strobe), .serial_out(serial_out), .readback_active(readback_active),
        .fast_mode(fast_mode), .cfg(cfg), .power_down(power_down), .clamp_dac_hiz(clamp_dac_hiz),
        .latency_mclk(latency_mclk), .zero_input_code(zero_input_code), .config_conflict(config_conflict));
    amc_host_model HOST (.mclk(mclk), .sclk(sclk), .serial_in(serial_in), .serial_strobe(serial_strobe),
        .serial_out(serial_out));

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        HOST.xfer({a, d}, 1'b0, 0, rdata);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        HOST.xfer({a | 6'h10, 8'h00}, 1'b1, 0, rdata);
        check("register", {8'h00, e}, {8'h00, rdata});
    endtask : rd_chk

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        logic [15:0] exp_code;
        srst = 1'b1;
        fast_mode = 1'b0;
        fails = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        check("power_down", 16'h0000, {15'h0000, power_down});
        for (int i = 0; i < 16; i++) rd_chk(addr_list[i], dflt_list[i]);
        rd_chk(6'h0D, 8'h00);
        for (int i = 0; i < 16; i++) begin
            if (addr_list[i] != ADDR_REVISION_ID) begin
                wr(addr_list[i], 8'h3C + 8'(i));
                rd_chk(addr_list[i], 8'h3C + 8'(i));
            end
        end
        wr(ADDR_REVISION_ID, 8'h00);
        rd_chk(ADDR_REVISION_ID, REV);
        HOST.xfer({ADDR_SPARE_A, 8'hC3}, 1'b0, 3, rdata);
        rd_chk(ADDR_SPARE_A, 8'hC3);
        wr(ADDR_OFFSET_ALL, 8'h5C);
        wr(ADDR_GAIN_ALL, 8'hA6);
        for (int k = 0; k < 3; k++) begin
            rd_chk(ADDR_OFFSET_RED + 6'(k), 8'h5C);
            rd_chk(ADDR_GAIN_RED + 6'(k), 8'hA6);
        end
        for (int r = 0; r < 8; r++) begin
            wr(ADDR_SETUP_ONE, {2'b00, r[1:0], 3'b111, ~r[2]});
            wr(ADDR_SETUP_TWO, {4'b0010, r[2], r[2], 2'b11});
            exp_code = (r[1:0] == 2'h2) ? 16'hFFFF : ((r[1:0] == 2'h3) ? 16'h0000 : 16'h7FFF);
            if (r[2]) exp_code = ~exp_code;
            check("zero_code", exp_code, zero_input_code);
            check("clamp_hiz", {15'h0000, r[2]}, {15'h0000, clamp_dac_hiz});
            check("power_down", {15'h0000, r[2]}, {15'h0000, power_down});
        end
        wr(ADDR_SETUP_TWO, 8'hE3);
        check("latency", 16'h0006, {12'h000, latency_mclk});
        wr(ADDR_SETUP_ONE, 8'h0D);
        check("latency", 16'h0006, {12'h000, latency_mclk});
        check("conflict", 16'h0000, {15'h0000, config_conflict});
        fast_mode = 1'b1;
        wr(ADDR_SETUP_ONE, 8'h0F);
        check("latency", 16'h0009, {12'h000, latency_mclk});
        check("conflict", 16'h0001, {15'h0000, config_conflict});
        wr(ADDR_SETUP_THREE, 8'h0F);
        check("conflict", 16'h0000, {15'h0000, config_conflict});
        fast_mode = 1'b0;
        wr(ADDR_SETUP_ONE, 8'h4F);
        check("conflict", 16'h0001, {15'h0000, config_conflict});
        wr(ADDR_SETUP_ONE, 8'h4D);
        check("conflict", 16'h0000, {15'h0000, config_conflict});
        wr(ADDR_SOFT_RESET, 8'hA7);
        rd_chk(ADDR_SETUP_ONE, 8'h0F);
        rd_chk(ADDR_SETUP_TWO, 8'h23);
        rd_chk(ADDR_SETUP_THREE, 8'h1F);
        rd_chk(ADDR_OFFSET_BLUE, 8'h80);
        rd_chk(ADDR_GAIN_RED, 8'h00);
        stop_test();
    end
endmodule : amc_regs_test

`default_nettype wire
